/* shared/tsc_pkg.sv */
/*
  constants for the transmit statistics counter bank: register offsets,
  reset values, frame-size bin limits and the counter index order.
  assumes a 16-bit byte address on a plain strobe-based register port.
*/
package tsc_pkg;

  localparam int unsigned TSC_ADDR_W = 16;
  localparam int unsigned TSC_DATA_W = 32;
  localparam int unsigned TSC_LEN_W  = 11;
  localparam int unsigned TSC_NCNT   = 7;

  localparam logic [15:0] TSC_OFF_MID_BIN = 16'h40e8;
  localparam logic [15:0] TSC_OFF_BIG_BIN = 16'h40ec;
  localparam logic [15:0] TSC_OFF_MCAST   = 16'h40f0;
  localparam logic [15:0] TSC_OFF_BCAST   = 16'h40f4;
  localparam logic [15:0] TSC_OFF_SEG_OK  = 16'h40f8;
  localparam logic [15:0] TSC_OFF_SEG_ERR = 16'h40fc;
  localparam logic [15:0] TSC_OFF_IRQ     = 16'h4100;
  localparam logic [15:0] TSC_OFF_CTRL    = 16'h4180;

  localparam logic [TSC_NCNT-1:0][15:0] TSC_CNT_OFFS = {
    TSC_OFF_IRQ, TSC_OFF_SEG_ERR, TSC_OFF_SEG_OK, TSC_OFF_BCAST,
    TSC_OFF_MCAST, TSC_OFF_BIG_BIN, TSC_OFF_MID_BIN};

  localparam int unsigned TSC_IX_MID_BIN = 0;
  localparam int unsigned TSC_IX_BIG_BIN = 1;
  localparam int unsigned TSC_IX_MCAST   = 2;
  localparam int unsigned TSC_IX_BCAST   = 3;
  localparam int unsigned TSC_IX_SEG_OK  = 4;
  localparam int unsigned TSC_IX_SEG_ERR = 5;
  localparam int unsigned TSC_IX_IRQ     = 6;

  localparam int unsigned TSC_CTRL_TX_EN  = 0;
  localparam int unsigned TSC_CTRL_TSO_EN = 1;

  localparam logic [31:0] TSC_CNT_RST  = 32'h0000_0000;
  localparam logic [1:0]  TSC_CTRL_RST = 2'h0;

  localparam logic [10:0] TSC_LEN_MID_MIN = 11'h200;
  localparam logic [10:0] TSC_LEN_MID_MAX = 11'h3ff;
  localparam logic [10:0] TSC_LEN_BIG_MIN = 11'h400;
  localparam logic [10:0] TSC_LEN_MAX     = 11'h5f2;

  typedef struct packed {
    logic [TSC_NCNT-1:0][31:0] cnt;
    logic [31:0]               rdata;
    logic                      tx_en;
    logic                      tso_en;
    logic                      irq_prev;
    logic                      fail_seen;
  } tsc_state_t;

endpackage

/* rtl/tsc_counters.sv */
/*
  transmit statistics counter bank: seven 32-bit counters fed by event
  strobes from the transmit mac, the segmentation engine and the legacy
  interrupt line, plus a control register with the transmit and
  segmentation-offload enables. all event inputs come from logic on
  i_ref_clk; software uses the plain strobe register port.
*/
`timescale 1ns/1ns
module tsc_counters
  import tsc_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [TSC_ADDR_W-1:0] i_addr,
  input  wire logic [TSC_DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr_stb,
  input  wire logic                  i_rd_stb,
  output logic      [TSC_DATA_W-1:0] o_rdata,
  input  wire logic                  i_frame_done,
  input  wire logic [TSC_LEN_W-1:0]  i_frame_len,
  input  wire logic                  i_frame_partial,
  input  wire logic                  i_frame_mcast,
  input  wire logic                  i_frame_bcast,
  input  wire logic                  i_frame_flowctl,
  input  wire logic                  i_seg_ctx_start,
  input  wire logic                  i_seg_ctx_done,
  input  wire logic                  i_seg_fail,
  input  wire logic                  i_paylen_err,
  input  wire logic                  i_legacy_irq,
  output logic                       o_tx_en,
  output logic                       o_tso_en
);

  ////////////////////////////////////////////////////////////////////////
  // event qualification

  tsc_state_t          s_q;
  tsc_state_t          s_d;
  logic [TSC_NCNT-1:0] inc;
  logic [TSC_NCNT-1:0] wr_hit;
  logic                frame_ok;
  logic                len_mid;
  logic                len_big;
  logic                seen_eff;
  logic                fail_ev;
  logic                ctrl_hit;

  // a frame counts only when fully sent and transmit is on
  assign frame_ok = i_frame_done & ~i_frame_partial & s_q.tx_en;
  assign len_mid  = (i_frame_len >= TSC_LEN_MID_MIN) & (i_frame_len <= TSC_LEN_MID_MAX);
  // above the ceiling the mac cannot send; such a length is ignored
  assign len_big  = (i_frame_len >= TSC_LEN_BIG_MIN) & (i_frame_len <= TSC_LEN_MAX);

  // a new context start forgets the previous context's failure
  assign seen_eff = s_q.fail_seen & ~i_seg_ctx_start;
  // only the count is kept, no byte progress is tracked
  assign fail_ev  = (i_seg_fail | i_paylen_err) & s_q.tx_en & ~seen_eff;

  // secure or clear frames use the same strobes, no type filter here
  assign inc[TSC_IX_MID_BIN] = frame_ok & len_mid;
  assign inc[TSC_IX_BIG_BIN] = frame_ok & len_big;
  assign inc[TSC_IX_MCAST]   = frame_ok & i_frame_mcast & ~i_frame_flowctl;
  assign inc[TSC_IX_BCAST]   = frame_ok & i_frame_bcast;
  assign inc[TSC_IX_SEG_OK]  = i_seg_ctx_done & s_q.tx_en & s_q.tso_en;
  assign inc[TSC_IX_SEG_ERR] = fail_ev;
  assign inc[TSC_IX_IRQ]     = i_legacy_irq & ~s_q.irq_prev & s_q.tx_en;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  // the interrupt counter is read only, so it never takes a write hit
  genvar gi;
  generate
    for (gi = 0; gi < TSC_NCNT; gi++) begin : g_hit
      if (gi == TSC_IX_IRQ) begin : g_ro
        assign wr_hit[gi] = 1'b0;
      end else begin : g_rw
        assign wr_hit[gi] = i_wr_stb & (i_addr == TSC_CNT_OFFS[gi]);
      end
    end
  endgenerate

  assign ctrl_hit = i_wr_stb & (i_addr == TSC_OFF_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.irq_prev = i_legacy_irq;
    if (i_seg_ctx_start) begin
      s_d.fail_seen = 1'b0;
    end
    if (fail_ev) begin
      s_d.fail_seen = 1'b1;
    end
    if (i_seg_ctx_done) begin
      s_d.fail_seen = 1'b0;
    end
    // a write and an event in one cycle both land; wrap is natural
    for (int i = 0; i < TSC_NCNT; i++) begin
      if (wr_hit[i]) begin
        s_d.cnt[i] = i_wdata + {31'h0000_0000, inc[i]};
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + {31'h0000_0000, inc[i]};
      end
    end
    if (ctrl_hit) begin
      s_d.tx_en  = i_wdata[TSC_CTRL_TX_EN];
      s_d.tso_en = i_wdata[TSC_CTRL_TSO_EN];
    end
    // read data stands for exactly one cycle, zero otherwise
    s_d.rdata = 32'h0000_0000;
    if (i_rd_stb) begin
      for (int i = 0; i < TSC_NCNT; i++) begin
        if (i_addr == TSC_CNT_OFFS[i]) begin
          s_d.rdata = s_q.cnt[i];
        end
      end
      if (i_addr == TSC_OFF_CTRL) begin
        s_d.rdata = {30'h0000_0000, s_q.tso_en, s_q.tx_en};
      end
    end
    if (i_sys_rst) begin
      s_d.cnt       = {TSC_NCNT{TSC_CNT_RST}};
      s_d.rdata     = 32'h0000_0000;
      s_d.tx_en     = TSC_CTRL_RST[TSC_CTRL_TX_EN];
      s_d.tso_en    = TSC_CTRL_RST[TSC_CTRL_TSO_EN];
      s_d.irq_prev  = 1'b0;
      s_d.fail_seen = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s_q <= s_d;
  end

  assign o_rdata  = s_q.rdata;
  assign o_tx_en  = s_q.tx_en;
  assign o_tso_en = s_q.tso_en;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic past_valid_q;
  always_ff @(posedge i_ref_clk) begin
    past_valid_q <= ~i_sys_rst;
  end

  sequence seq_first_fail;
    (i_seg_fail | i_paylen_err) & s_q.tx_en & ~s_q.fail_seen & ~i_seg_ctx_start & ~i_seg_ctx_done
    & ~wr_hit[TSC_IX_SEG_ERR];
  endsequence

  sequence seq_repeat_fail;
    (i_seg_fail | i_paylen_err) & ~i_seg_ctx_start & ~wr_hit[TSC_IX_SEG_ERR];
  endsequence

  sequence seq_irq_rise;
    ~i_legacy_irq ##1 i_legacy_irq & s_q.tx_en & ~wr_hit[TSC_IX_IRQ];
  endsequence

  chk_mid_bin_inc: assert property (
    i_frame_done & ~i_frame_partial & s_q.tx_en & (i_frame_len == 11'h200) & ~wr_hit[TSC_IX_MID_BIN]
    |=> s_q.cnt[TSC_IX_MID_BIN] == $past(s_q.cnt[TSC_IX_MID_BIN]) + 32'h0000_0001)
    else $error("mid bin missed a frame");

  chk_partial_skip: assert property (
    i_frame_done & i_frame_partial & ~wr_hit[TSC_IX_MID_BIN] & ~wr_hit[TSC_IX_BIG_BIN]
    |=> $stable(s_q.cnt[TSC_IX_MID_BIN]) && $stable(s_q.cnt[TSC_IX_BIG_BIN]))
    else $error("partial frame counted in a size bin");

  chk_tx_off_hold: assert property (
    ~s_q.tx_en & ~i_wr_stb |=> $stable(s_q.cnt))
    else $error("counter moved with transmit disabled");

  chk_big_bin_inc: assert property (
    i_frame_done & ~i_frame_partial & s_q.tx_en & (i_frame_len == 11'h400) & ~wr_hit[TSC_IX_BIG_BIN]
    |=> s_q.cnt[TSC_IX_BIG_BIN] == $past(s_q.cnt[TSC_IX_BIG_BIN]) + 32'h0000_0001)
    else $error("large bin missed a 1024 byte frame");

  chk_max_len_inc: assert property (
    i_frame_done & ~i_frame_partial & s_q.tx_en & (i_frame_len == 11'h5f2) & ~wr_hit[TSC_IX_BIG_BIN]
    |=> s_q.cnt[TSC_IX_BIG_BIN] == $past(s_q.cnt[TSC_IX_BIG_BIN]) + 32'h0000_0001
        ##1 1'b1)
    else $error("1522 byte frame not counted large");

  chk_bin_exclusive: assert property (
    i_frame_done & (i_frame_len == 11'h3ff) & ~i_wr_stb
    |=> $stable(s_q.cnt[TSC_IX_BIG_BIN]))
    else $error("1023 byte frame reached large bin");

  chk_mcast_flowctl: assert property (
    i_frame_done & i_frame_flowctl & ~wr_hit[TSC_IX_MCAST]
    |=> $stable(s_q.cnt[TSC_IX_MCAST]))
    else $error("flow control frame counted as multicast");

  chk_mcast_inc: assert property (
    frame_ok & i_frame_mcast & ~i_frame_flowctl & ~wr_hit[TSC_IX_MCAST]
    |=> s_q.cnt[TSC_IX_MCAST] == $past(s_q.cnt[TSC_IX_MCAST]) + 32'h0000_0001)
    else $error("multicast frame not counted");

  chk_bcast_inc: assert property (
    frame_ok & i_frame_bcast & ~wr_hit[TSC_IX_BCAST]
    |=> s_q.cnt[TSC_IX_BCAST] == $past(s_q.cnt[TSC_IX_BCAST]) + 32'h0000_0001)
    else $error("broadcast frame not counted");

  chk_seg_ctx_gate: assert property (
    i_seg_ctx_done & ~s_q.tso_en & ~wr_hit[TSC_IX_SEG_OK]
    |=> $stable(s_q.cnt[TSC_IX_SEG_OK]))
    else $error("context counted with offload disabled");

  chk_seg_ctx_inc: assert property (
    i_seg_ctx_done & s_q.tso_en & s_q.tx_en & ~wr_hit[TSC_IX_SEG_OK]
    |=> s_q.cnt[TSC_IX_SEG_OK] == $past(s_q.cnt[TSC_IX_SEG_OK]) + 32'h0000_0001)
    else $error("finished context not counted");

  chk_fail_once: assert property (
    seq_first_fail ##1 seq_repeat_fail
    |=> s_q.cnt[TSC_IX_SEG_ERR] == $past(s_q.cnt[TSC_IX_SEG_ERR], 2) + 32'h0000_0001)
    else $error("second failure in one context counted");

  chk_paylen_fail: assert property (
    i_paylen_err & s_q.tx_en & ~s_q.fail_seen & ~wr_hit[TSC_IX_SEG_ERR]
    |=> s_q.cnt[TSC_IX_SEG_ERR] == $past(s_q.cnt[TSC_IX_SEG_ERR]) + 32'h0000_0001)
    else $error("payload length error not counted");

  chk_irq_count: assert property (
    seq_irq_rise |=> s_q.cnt[TSC_IX_IRQ] == $past(s_q.cnt[TSC_IX_IRQ]) + 32'h0000_0001)
    else $error("legacy interrupt edge not counted");

  chk_irq_read_only: assert property (
    i_wr_stb & (i_addr == TSC_OFF_IRQ) & ~inc[TSC_IX_IRQ]
    |=> $stable(s_q.cnt[TSC_IX_IRQ]))
    else $error("interrupt counter took a write");

  chk_reset_zero: assert property (
    disable iff (1'b0) i_sys_rst |=> (s_q.cnt == '0) && (o_rdata == 32'h0000_0000))
    else $error("counter not zero after reset");

  chk_write_adds: assert property (
    wr_hit[TSC_IX_BCAST] & inc[TSC_IX_BCAST]
    |=> s_q.cnt[TSC_IX_BCAST] == $past(i_wdata) + 32'h0000_0001)
    else $error("event lost against a write");

  chk_read_once: assert property (
    past_valid_q & ~i_rd_stb |=> o_rdata == 32'h0000_0000)
    else $error("read data stood beyond its cycle");

  ////////////////////////////////////////////////////////////////////////
  // bin edges, gating and register port

  chk_mid_bin_max: assert property (
    frame_ok & (i_frame_len == 11'h3ff) & ~wr_hit[TSC_IX_MID_BIN]
    |=> s_q.cnt[TSC_IX_MID_BIN] == $past(s_q.cnt[TSC_IX_MID_BIN]) + 32'h0000_0001)
    else $error("1023 byte frame missed the mid bin");

  chk_mid_bin_low: assert property (
    i_frame_done & (i_frame_len == 11'h1ff) & ~wr_hit[TSC_IX_MID_BIN]
    |=> $stable(s_q.cnt[TSC_IX_MID_BIN]))
    else $error("511 byte frame reached the mid bin");

  chk_over_max_skip: assert property (
    i_frame_done & (i_frame_len == 11'h5f3) & ~wr_hit[TSC_IX_BIG_BIN]
    |=> $stable(s_q.cnt[TSC_IX_BIG_BIN]))
    else $error("frame above the ceiling counted large");

  chk_partial_casts: assert property (
    i_frame_done & i_frame_partial & ~wr_hit[TSC_IX_MCAST] & ~wr_hit[TSC_IX_BCAST]
    |=> $stable(s_q.cnt[TSC_IX_MCAST]) && $stable(s_q.cnt[TSC_IX_BCAST]))
    else $error("partial frame counted as multicast or broadcast");

  chk_small_frame_skip: assert property (
    i_frame_done & (i_frame_len <= 11'h0c8) & ~wr_hit[TSC_IX_MID_BIN] & ~wr_hit[TSC_IX_BIG_BIN]
    |=> $stable(s_q.cnt[TSC_IX_MID_BIN]) && $stable(s_q.cnt[TSC_IX_BIG_BIN]))
    else $error("short frame reached a size bin");

  chk_tx_off_irq: assert property (
    ~s_q.tx_en |=> $stable(s_q.cnt[TSC_IX_IRQ]))
    else $error("interrupt counter moved with transmit disabled");

  chk_tx_off_seg: assert property (
    ~s_q.tx_en & ~wr_hit[TSC_IX_SEG_OK] & ~wr_hit[TSC_IX_SEG_ERR]
    |=> $stable(s_q.cnt[TSC_IX_SEG_OK]) && $stable(s_q.cnt[TSC_IX_SEG_ERR]))
    else $error("context counter moved with transmit disabled");

  chk_bcast_gate: assert property (
    ~(i_frame_done & i_frame_bcast) & ~wr_hit[TSC_IX_BCAST]
    |=> $stable(s_q.cnt[TSC_IX_BCAST]))
    else $error("broadcast counter moved without a broadcast frame");

  chk_mcast_gate: assert property (
    ~(i_frame_done & i_frame_mcast) & ~wr_hit[TSC_IX_MCAST]
    |=> $stable(s_q.cnt[TSC_IX_MCAST]))
    else $error("multicast counter moved without a multicast frame");

  chk_seg_ctx_only: assert property (
    ~i_seg_ctx_done & ~wr_hit[TSC_IX_SEG_OK]
    |=> $stable(s_q.cnt[TSC_IX_SEG_OK]))
    else $error("context counter moved without a finished context");

  chk_fail_gate: assert property (
    ~i_seg_fail & ~i_paylen_err & ~wr_hit[TSC_IX_SEG_ERR]
    |=> $stable(s_q.cnt[TSC_IX_SEG_ERR]))
    else $error("failure counter moved without a failure");

  chk_fail_flag_set: assert property (
    fail_ev & ~i_seg_ctx_done |=> s_q.fail_seen)
    else $error("failure not remembered for its context");

  chk_fail_flag_clear: assert property (
    i_seg_ctx_done |=> ~s_q.fail_seen)
    else $error("failure memory kept past context end");

  chk_fail_new_ctx: assert property (
    i_seg_ctx_start & (i_seg_fail | i_paylen_err) & s_q.tx_en & ~wr_hit[TSC_IX_SEG_ERR]
    |=> s_q.cnt[TSC_IX_SEG_ERR] == $past(s_q.cnt[TSC_IX_SEG_ERR]) + 32'h0000_0001)
    else $error("failure at context start not counted");

  chk_irq_level_hold: assert property (
    i_legacy_irq & s_q.irq_prev |=> $stable(s_q.cnt[TSC_IX_IRQ]))
    else $error("held interrupt level counted twice");

  chk_ctrl_write: assert property (
    ctrl_hit
    |=> (s_q.tx_en == $past(i_wdata[TSC_CTRL_TX_EN])) && (s_q.tso_en == $past(i_wdata[TSC_CTRL_TSO_EN])))
    else $error("control write not taken");

  chk_ctrl_hold: assert property (
    ~ctrl_hit |=> $stable(s_q.tx_en) && $stable(s_q.tso_en))
    else $error("enables changed without a control write");

  chk_read_mcast: assert property (
    i_rd_stb & (i_addr == TSC_OFF_MCAST)
    |=> o_rdata == $past(s_q.cnt[TSC_IX_MCAST]))
    else $error("multicast count read back wrong");

  chk_read_irq: assert property (
    i_rd_stb & (i_addr == TSC_OFF_IRQ)
    |=> o_rdata == $past(s_q.cnt[TSC_IX_IRQ]))
    else $error("interrupt count read back wrong");

  chk_read_ctrl: assert property (
    i_rd_stb & (i_addr == TSC_OFF_CTRL)
    |=> o_rdata == {30'h0000_0000, $past(s_q.tso_en), $past(s_q.tx_en)})
    else $error("control register read back wrong");

  chk_write_wrap: assert property (
    wr_hit[TSC_IX_BCAST] & inc[TSC_IX_BCAST] & (i_wdata == 32'hffff_ffff)
    |=> s_q.cnt[TSC_IX_BCAST] == 32'h0000_0000)
    else $error("counter did not wrap to zero");

  chk_write_plain: assert property (
    wr_hit[TSC_IX_MCAST] & ~inc[TSC_IX_MCAST]
    |=> s_q.cnt[TSC_IX_MCAST] == $past(i_wdata))
    else $error("write to multicast counter not taken");

endmodule

/* dv/tb.sv */
/*
  self-checking bench for the transmit statistics counter bank.
  assumes one clock, synchronous reset and the plain strobe register port.
*/
`timescale 1ns/1ns
module tb
  import tsc_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000, p_addr = 16'h0000;
  logic [31:0] i_wdata = 32'h0000_0000, p_wdata = 32'h0000_0000, o_rdata, v = 32'habed_f574;
  logic        i_wr_stb = 1'b0, i_rd_stb = 1'b0, i_legacy_irq = 1'b0, o_tx_en, o_tso_en, rd_q = 1'b0;
  logic [10:0] i_frame_len = 11'h000, p_len = 11'h000;
  logic        i_frame_done = 1'b0, i_frame_partial = 1'b0, i_frame_mcast = 1'b0, i_frame_bcast = 1'b0;
  logic        i_frame_flowctl = 1'b0, i_seg_ctx_start = 1'b0, i_seg_ctx_done = 1'b0;
  logic        i_seg_fail = 1'b0, i_paylen_err = 1'b0;
  logic [8:0]  p_ev = 9'h000;
  logic        p_wr = 1'b0, p_rd = 1'b0, p_irq = 1'b0, m_tx = 1'b0, m_tso = 1'b0, ff = 1'b0, irq_q = 1'b0;
  logic [31:0] m [7] = '{default: 32'h0000_0000};
  logic [31:0] exq [$];
  logic [10:0] lens [7] = '{11'h1ff, 11'h200, 11'h3ff, 11'h400, 11'h5f2, 11'h5f3, 11'h0c8};
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  tsc_counters DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_frame_done(i_frame_done),
    .i_frame_len(i_frame_len), .i_frame_partial(i_frame_partial), .i_frame_mcast(i_frame_mcast),
    .i_frame_bcast(i_frame_bcast), .i_frame_flowctl(i_frame_flowctl), .i_seg_ctx_start(i_seg_ctx_start),
    .i_seg_ctx_done(i_seg_ctx_done), .i_seg_fail(i_seg_fail), .i_paylen_err(i_paylen_err),
    .i_legacy_irq(i_legacy_irq), .o_tx_en(o_tx_en), .o_tso_en(o_tso_en));
  always #10 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] rdv(logic [15:0] a);
    logic [31:0] r;
    r = (a == TSC_OFF_CTRL) ? {30'h0000_0000, m_tso, m_tx} : 32'h0000_0000;
    for (int k = 0; k < 7; k++) if (a == TSC_CNT_OFFS[k]) r = m[k];
    return r;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one cycle of stimulus; the model follows what the edge after it takes
  task automatic tick();
    logic ok;
    @(posedge i_ref_clk);
    {i_wr_stb, i_rd_stb, i_addr, i_wdata, i_frame_len} <= {p_wr, p_rd, p_addr, p_wdata, p_len};
    {i_frame_done, i_frame_partial, i_frame_mcast, i_frame_bcast, i_frame_flowctl} <= p_ev[8:4];
    {i_seg_ctx_start, i_seg_ctx_done, i_seg_fail, i_paylen_err, i_legacy_irq} <= {p_ev[3:0], p_irq};
    if (p_rd) exq.push_back(rdv(p_addr));
    for (int k = 0; k < 6; k++) if (p_wr && p_addr == TSC_CNT_OFFS[k]) m[k] = p_wdata;
    ok = m_tx && p_ev[8] && !p_ev[7];
    if (ok && p_len >= 11'h200 && p_len <= 11'h3ff) m[0]++;
    if (ok && p_len >= 11'h400 && p_len <= 11'h5f2) m[1]++;
    if (ok && p_ev[6] && !p_ev[4]) m[2]++;
    if (ok && p_ev[5]) m[3]++;
    if (p_ev[3]) ff = 1'b0;
    if (m_tx && (p_ev[1] || p_ev[0]) && !ff) {m[5], ff} = {m[5] + 32'h0000_0001, 1'b1};
    if (p_ev[2]) {ff, m[4]} = {1'b0, m[4] + {31'h0000_0000, m_tx && m_tso}};
    if (m_tx && p_irq && !irq_q) m[6]++;
    irq_q = p_irq;
    if (p_wr && p_addr == TSC_OFF_CTRL) {m_tso, m_tx} = p_wdata[1:0];
    {p_wr, p_rd, p_ev} = '0;
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    {p_wr, p_addr, p_wdata} = {1'b1, a, d};
    tick();
  endtask
  task automatic rd(logic [15:0] a);
    {p_rd, p_addr} = {1'b1, a};
    tick();
  endtask
  task automatic rd_all();
    for (int k = 0; k < 7; k++) rd(TSC_CNT_OFFS[k]);
    rd(TSC_OFF_CTRL);
    rd(16'h4104);
  endtask
  task automatic fr(logic [10:0] len, logic [3:0] f);
    {p_len, p_ev[8:4]} = {len, 1'b1, f};
    tick();
  endtask
  task automatic sg(logic [3:0] b);
    p_ev[3:0] = b;
    tick();
  endtask
  task automatic irq_pulse();
    p_irq = 1'b1;
    repeat (2) tick();
    p_irq = 1'b0;
    tick();
  endtask
  task automatic en_chk();
    tick();
    #1 chk("enables", {30'h0000_0000, m_tso, m_tx}, {30'h0000_0000, o_tso_en, o_tx_en});
  endtask
  task automatic stop_test();
    chk("pending reads", 32'h0000_0000, 32'(exq.size()));
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) rd_q <= i_rd_stb;
  always @(negedge i_ref_clk) begin
    if (rd_q && exq.size() > 0) chk("rdata", exq.pop_front(), o_rdata);
    else if (!i_sys_rst) chk("rdata_idle", 32'h0000_0000, o_rdata);
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd_all();
    fr(11'h258, 4'b0110);
    sg(4'b0101);
    irq_pulse();
    rd_all();
    wr(TSC_OFF_CTRL, 32'h0000_0001);
    en_chk();
    foreach (lens[i]) fr(lens[i], 4'h0);
    for (int f = 0; f < 16; f++) fr(11'h2bc, f[3:0]);
    for (int i = 0; i < 40; i++) begin
      v = lfsr(v);
      fr(v[10:0], v[14:11]);
    end
    rd_all();
    sg(4'b0100);
    wr(TSC_OFF_CTRL, 32'h0000_0003);
    en_chk();
    sg(4'b1000);
    sg(4'b0100);
    sg(4'b0100);
    sg(4'b1000);
    sg(4'b0010);
    sg(4'b0010);
    sg(4'b0001);
    sg(4'b0100);
    sg(4'b1001);
    irq_pulse();
    irq_pulse();
    wr(TSC_OFF_IRQ, 32'h1234_5678);
    rd_all();
    {p_wr, p_addr, p_wdata} = {1'b1, TSC_OFF_BCAST, 32'hffff_ffff};
    fr(11'h5f2, 4'b0010);
    for (int k = 0; k < 7; k++) begin
      v = lfsr(v);
      wr(TSC_CNT_OFFS[k], v);
    end
    rd_all();
    tick();
    i_sys_rst <= 1'b1;
    @(posedge i_ref_clk);
    {m_tx, m_tso, ff, irq_q} = 4'h0;
    m = '{default: 32'h0000_0000};
    i_sys_rst <= 1'b0;
    rd_all();
    repeat (3) tick();
    stop_test();
  end
endmodule
